//--- common/clk_stop_cfg.svh
`ifndef CLK_STOP_CFG_SVH
`define CLK_STOP_CFG_SVH
// timing
`define CS_CLK_NS 20
`define CS_RESUME_NS 1800000
`define CS_PD_DRIVE_NS 300000
`define CS_STOP_DRIVE_NS 10
`define CS_SHARE_LOW_PS 7490
// register byte offsets
`define CS_CPU_CFG_OFF 8'h00
`define CS_SRC_CFG_OFF 8'h04
`define CS_STATUS_OFF 8'h08
// cpu config fields, one bit per pair
`define CS_CPU_OE_LSB 0
`define CS_CPU_STOPPABLE_LSB 4
`define CS_CPU_STRI_LSB 8
`define CS_CPU_PTRI_LSB 12
`define CS_CPU_CFG_MASK 32'h0000_7777
`define CS_CPU_CFG_RST 32'h0000_0077
// src and shared pin config fields
`define CS_SRC_OE_BIT 0
`define CS_SRC_STOPPABLE_BIT 1
`define CS_SRC_STRI_BIT 2
`define CS_SRC_PTRI_BIT 3
`define CS_SHARE_SEL_BIT 4
`define CS_SW_STOP_N_BIT 5
`define CS_SRC_CFG_MASK 32'h0000_003F
`define CS_SRC_CFG_RST 32'h0000_0021
// status fields
`define CS_ST_PIN_LSB 0
`define CS_ST_PWR_LSB 3
`define CS_ST_PARK_LSB 7
`define CS_ST_SHARE_LSB 11
`define CS_ST_OSC_BIT 14
`endif

//--- common/clk_stop_pkg.sv
package clk_stop_pkg;
	typedef enum logic [2:0] {PS_RUN = 3'b001, PS_STOP = 3'b010,
		PS_PD = 3'b100} pair_st_e;
	typedef enum logic [3:0] {PW_RUN = 4'b0001, PW_ENTER = 4'b0010,
		PW_OFF = 4'b0100, PW_RESUME = 4'b1000} pwr_st_e;
	typedef enum logic [2:0] {SH_66 = 3'b001, SH_LOW = 3'b010,
		SH_48 = 3'b100} share_st_e;
endpackage : clk_stop_pkg

//--- common/pair_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pair_if;
	logic phase;
	logic tick;
	logic stop_req;
	logic free_run;
	logic oe;
	logic stop_tri;
	logic pd_tri;
	logic pd_req;
	logic resume_drive;
	logic true_o;
	logic comp_o;
	logic true_oe_n;
	logic comp_oe_n;
	logic drive_x6;
	logic drive_x2;
	logic parked;
	modport ctl (output phase, tick, stop_req, free_run, oe, stop_tri,
		pd_tri, pd_req, resume_drive, input true_o, comp_o, true_oe_n,
		comp_oe_n, drive_x6, drive_x2, parked);
	modport pair (input phase, tick, stop_req, free_run, oe, stop_tri,
		pd_tri, pd_req, resume_drive, output true_o, comp_o, true_oe_n,
		comp_oe_n, drive_x6, drive_x2, parked);
endinterface : pair_if
`default_nettype wire

//--- dv/host_pins.sv
`timescale 1ns/100ps
`default_nettype none
module host_pins (
	input wire logic aclk,
	input wire logic [2:0] want,
	output logic cpu_stop_n,
	output logic pci_stop_n,
	output logic powerdown_n
);
	// the pins change on aclk rising edges, the device clock; its synchronisers still delay them
	always @(posedge aclk) begin
		{powerdown_n, pci_stop_n, cpu_stop_n} <= ~want;
	end
endmodule : host_pins
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic aclk, aresetn, tgl;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb, c66;
	logic [1:0] bresp, rresp, resp;
	logic [2:0] want, ct, cc, ctn, ccn, cx6, cx2, fpc;
	logic cpu_stop_n, pci_stop_n, powerdown_n;
	logic st, sc, stn, scn, sx6, sx2, dot, shr, osc;
	int errors, tests_run, n;

	host_pins host (.aclk(aclk), .want(want), .cpu_stop_n(cpu_stop_n),
		.pci_stop_n(pci_stop_n), .powerdown_n(powerdown_n));

	clk_stop_ctl #(.RESUME_CYC(50), .PD_DRIVE_CYC(20)) DUT (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
		.powerdown_n(powerdown_n), .cpu_true(ct), .cpu_comp(cc),
		.cpu_true_oe_n(ctn), .cpu_comp_oe_n(ccn), .cpu_drive_x6(cx6),
		.cpu_drive_x2(cx2), .serial_ref_pair_true(st),
		.serial_ref_pair_comp(sc), .serial_ref_pair_true_oe_n(stn),
		.serial_ref_pair_comp_oe_n(scn), .serial_ref_pair_drive_x6(sx6),
		.serial_ref_pair_drive_x2(sx2), .clk66_output(c66),
		.free_periph_clock(fpc), .dot_clock_48(dot),
		.shared_66_48_pin(shr), .osc_run(osc));

	task end_of_test;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// a wait that ran out of cycles ends the run
	task lim(input int c);
		if (n >= c) begin
			errors++;
			$display("BAD wait expected %0d seen %0d", c, n);
			end_of_test();
		end
	endtask : lim

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && awready !== 1'b1; n++) @(negedge aclk);
		lim(50);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(negedge aclk);
		lim(50);
		@(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && arready !== 1'b1; n++) @(negedge aclk);
		lim(50);
		@(posedge aclk);
		arvalid <= 1'b0;
		for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(negedge aclk);
		lim(50);
		@(posedge aclk);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rdr

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		end_of_test();
	end

	initial begin
		errors = 0;
		tests_run = 0;
		aresetn = 1'b0;
		{awaddr, araddr, wdata, wstrb, want} = {48'h0, 4'hF, 3'h0};
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(8'h00);
		chk("cpu_cfg", 32'h0000_0077, rd);
		rdr(8'h04);
		chk("src_cfg", 32'h0000_0021, rd);
		rdr(8'h0C);
		chk("unmapped", 32'h0000_0002, {30'h0, resp});
		wr(8'h08, 32'h0000_0000);
		chk("status write", 32'h0000_0002, {30'h0, resp});
		wr(8'h00, 32'hFFFF_FFFF);
		chk("write resp", 32'h0000_0000, {30'h0, resp});
		rdr(8'h00);
		chk("cpu mask", 32'h0000_7777, rd);
		wr(8'h00, 32'h0000_4236);
		repeat (4) @(posedge aclk);
		chk("disabled", 32'h0000_0003, {30'h0, ctn[0], ccn[0]});
		wr(8'h00, 32'h0000_4237);
		want <= 3'h1;
		for (n = 0; n < 40 && cx6[0] !== 1'b1; n++) @(negedge aclk);
		lim(40);
		chk("park", 32'h0000_0004, {29'h0, ct[0], cc[0], ctn[0]});
		chk("park x6", 32'h0000_0001, {31'h0, cx6[0]});
		chk("stop tri", 32'h0000_0003, {30'h0, ctn[1], ccn[1]});
		tgl = ct[2];
		for (n = 0; n < 8 && ct[2] === tgl; n++) @(negedge aclk);
		lim(8);
		want <= 3'h0;
		for (n = 0; n < 8 && ctn[1] !== 1'b0; n++) @(negedge aclk);
		lim(8);
		for (n = 0; n < 20 && cx6[0] !== 1'b0; n++) @(negedge aclk);
		lim(20);
		wr(8'h04, 32'h0000_0023);
		want <= 3'h2;
		for (n = 0; n < 40 && sx6 !== 1'b1; n++) @(negedge aclk);
		lim(40);
		chk("src park", 32'h0000_0002, {30'h0, st, sc});
		chk("src drv", 32'h0000_0000, {30'h0, stn, scn});
		tgl = fpc[0];
		for (n = 0; n < 12 && fpc[0] === tgl; n++) @(negedge aclk);
		lim(12);
		want <= 3'h0;
		for (n = 0; n < 40 && sx6 !== 1'b0; n++) @(negedge aclk);
		lim(40);
		want <= 3'h4;
		for (n = 0; n < 200 && osc !== 1'b0; n++) @(negedge aclk);
		lim(200);
		chk("se low", 32'h0000_0000, {24'h0, dot, fpc, c66});
		chk("pd drv", 32'h0000_000D, {28'h0, cx2[0], ct[0], ctn[0], ccn[0]});
		chk("pd tri", 32'h0000_0003, {30'h0, ctn[2], ccn[2]});
		chk("src pd", 32'h0000_0001, {31'h0, sx2});
		want <= 3'h0;
		for (n = 0; n < 40 && ctn[2] !== 1'b0; n++) @(negedge aclk);
		lim(40);
		for (n = 0; n < 120 && cx2[0] !== 1'b0; n++) @(negedge aclk);
		lim(120);
		rdr(8'h08);
		chk("share 66", 32'h0000_0001, {29'h0, rd[13:11]});
		wr(8'h04, 32'h0000_0033);
		repeat (30) @(posedge aclk);
		rdr(8'h08);
		chk("share 48", 32'h0000_0004, {29'h0, rd[13:11]});
		tgl = shr;
		for (n = 0; n < 8 && shr === tgl; n++) @(negedge aclk);
		lim(8);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire

//--- hdl/clk_stop_ctl.sv
// Behaviour
// - cpu stop halts stoppable cpu pairs; free ones run
// - stop, drive bit 0: true high, complement low
// - stop, tristate bit 1: both legs tristated
// - stop release resumes glitch free, 2-6 periods
// - tristated stopped pair driven high after release
// - power-down parks clocks, then oscillator off
// - power-down needs two complement-rise low samples
// - single-ended clocks held low from next fall
// - pairs held high from next complement fall
// - pd drive bit 0: true x2, complement float
// - clocks stable under 1.8ms after release
// - pd-tristated pair driven high within 300us
// - shared pin 66MHz default, 48MHz when selected
// - switch: low at 66 fall, then 48
// - four independent controls per differential output
// - disabled pair always tristated
// - stop drives x6, power-down x2, all pairs
// - serial ref pair follows peripheral stop scheme
// - stop driven, pd tristate: float in pd only
// - cpu stop sampled at resume window end
// - peripheral stop sampled at resume window end
// - both drive bits 0 never tristates the true leg
// - free-running outputs ignore pin and soft stop
`timescale 1ns/100ps
`default_nettype none
`include "clk_stop_cfg.svh"
module clk_stop_ctl #(
	parameter int NCPU = 3,
	parameter int CPU_HALF = 1,
	parameter int C66_HALF = 2,
	parameter int C48_HALF = 3,
	parameter int PCI_HALF = 4,
	parameter int RESUME_CYC = `CS_RESUME_NS / `CS_CLK_NS,
	parameter int PD_DRIVE_CYC = `CS_PD_DRIVE_NS / `CS_CLK_NS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic cpu_stop_n,
	input wire logic pci_stop_n,
	input wire logic powerdown_n,
	output logic [NCPU-1:0] cpu_true,
	output logic [NCPU-1:0] cpu_comp,
	output logic [NCPU-1:0] cpu_true_oe_n,
	output logic [NCPU-1:0] cpu_comp_oe_n,
	output logic [NCPU-1:0] cpu_drive_x6,
	output logic [NCPU-1:0] cpu_drive_x2,
	output logic serial_ref_pair_true,
	output logic serial_ref_pair_comp,
	output logic serial_ref_pair_true_oe_n,
	output logic serial_ref_pair_comp_oe_n,
	output logic serial_ref_pair_drive_x6,
	output logic serial_ref_pair_drive_x2,
	output logic [3:0] clk66_output,
	output logic [2:0] free_periph_clock,
	output logic dot_clock_48,
	output logic shared_66_48_pin,
	output logic osc_run
);
	localparam int NPAIR = NCPU + 1;
	localparam int HALF [4] = '{CPU_HALF, C66_HALF, C48_HALF, PCI_HALF};
	localparam int SHARE_LOW_RAW = (`CS_SHARE_LOW_PS + `CS_CLK_NS * 1000 - 1)
		/ (`CS_CLK_NS * 1000);
	localparam int SHARE_LOW_CYC = (SHARE_LOW_RAW < 1) ? 1 : SHARE_LOW_RAW;
	localparam int STOP_DRIVE_RAW = `CS_STOP_DRIVE_NS / `CS_CLK_NS;
	localparam int STOP_DRIVE_CYC = (STOP_DRIVE_RAW < 1) ? 1 : STOP_DRIVE_RAW;
	localparam int RW = $clog2(RESUME_CYC + 1);
	localparam int DW = $clog2(PD_DRIVE_CYC + 1);

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				res[8*b +: 8] = new_v[8*b +: 8];
		end
		return res;
	endfunction : merge_strb

	// pin synchronisers: bit0 cpu stop, bit1 peripheral stop, bit2 power-down
	logic [2:0] pin_s1_ff, pin_s2_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff <= 3'h7;
			pin_s2_ff <= 3'h7;
		end else begin
			pin_s1_ff <= {powerdown_n, pci_stop_n, cpu_stop_n};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// register file
	logic [31:0] cpu_cfg_ff, src_cfg_ff, status;
	logic bvalid_ff, rvalid_ff, wr_go;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	assign wr_go = awvalid && wvalid && !bvalid_ff;
	assign awready = wr_go;
	assign wready = wr_go;
	assign arready = !rvalid_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_cfg_ff <= `CS_CPU_CFG_RST;
			src_cfg_ff <= `CS_SRC_CFG_RST;
		end else if (wr_go && awaddr == `CS_CPU_CFG_OFF) begin
			cpu_cfg_ff <= merge_strb(cpu_cfg_ff, wdata, wstrb) & `CS_CPU_CFG_MASK;
		end else if (wr_go && awaddr == `CS_SRC_CFG_OFF) begin
			src_cfg_ff <= merge_strb(src_cfg_ff, wdata, wstrb) & `CS_SRC_CFG_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (awaddr == `CS_CPU_CFG_OFF || awaddr == `CS_SRC_CFG_OFF)
				? 2'h0 : 2'h2;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= 2'h0;
			rdata_ff <= 32'h0;
		end else if (arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= 2'h0;
			case (araddr)
				`CS_CPU_CFG_OFF: rdata_ff <= cpu_cfg_ff;
				`CS_SRC_CFG_OFF: rdata_ff <= src_cfg_ff;
				`CS_STATUS_OFF: rdata_ff <= status;
				default: begin
					rdata_ff <= 32'h0;
					rresp_ff <= 2'h2;
				end
			endcase
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// clock phase generators; the oscillator gate freezes all of them
	logic osc_run_ff;
	logic [3:0] phase_ff, tick, fall;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_div
			logic [7:0] cnt_ff;
			assign tick[g] = osc_run_ff && cnt_ff == 8'(HALF[g] - 1);
			assign fall[g] = tick[g] && phase_ff[g];
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cnt_ff <= 8'h0;
					phase_ff[g] <= 1'b0;
				end else if (tick[g]) begin
					cnt_ff <= 8'h0;
					phase_ff[g] <= !phase_ff[g];
				end else if (osc_run_ff) begin
					cnt_ff <= cnt_ff + 8'h1;
				end
			end
		end
	endgenerate

	// power-down sampling on complement rising edges (true falling)
	logic [1:0] pd_cnt_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || pin_s2_ff[2])
			pd_cnt_ff <= 2'h0;
		else if (fall[0] && pd_cnt_ff != 2'h2)
			pd_cnt_ff <= pd_cnt_ff + 2'h1;
	end

	clk_stop_pkg::pwr_st_e pw_st_ff, nxt_pw;
	logic [RW-1:0] res_cnt_ff;
	logic [2:0] hold_ff;
	logic [NPAIR-1:0] parked;
	logic all_parked;
	assign all_parked = (&parked) && (&hold_ff);

	always_comb begin
		nxt_pw = pw_st_ff;
		case (pw_st_ff)
			clk_stop_pkg::PW_RUN:
				if (pd_cnt_ff == 2'h2)
					nxt_pw = clk_stop_pkg::PW_ENTER;
			clk_stop_pkg::PW_ENTER:
				if (all_parked)
					nxt_pw = clk_stop_pkg::PW_OFF;
			clk_stop_pkg::PW_OFF:
				if (pin_s2_ff[2])
					nxt_pw = clk_stop_pkg::PW_RESUME;
			clk_stop_pkg::PW_RESUME:
				if (res_cnt_ff == RW'(RESUME_CYC - 1))
					nxt_pw = clk_stop_pkg::PW_RUN;
			default: nxt_pw = clk_stop_pkg::PW_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pw_st_ff <= clk_stop_pkg::PW_RUN;
			res_cnt_ff <= '0;
			osc_run_ff <= 1'b1;
		end else begin
			pw_st_ff <= nxt_pw;
			res_cnt_ff <= (pw_st_ff == clk_stop_pkg::PW_RESUME)
				? res_cnt_ff + RW'(1) : '0;
			osc_run_ff <= (nxt_pw != clk_stop_pkg::PW_OFF);
		end
	end

	// single-ended holds: 66, 48 and peripheral clocks
	generate
		for (g = 1; g < 4; g++) begin : g_hold
			always_ff @(posedge aclk) begin
				if (!aresetn)
					hold_ff[g-1] <= 1'b0;
				else if (pw_st_ff == clk_stop_pkg::PW_ENTER && fall[g])
					hold_ff[g-1] <= 1'b1;
				else if (pw_st_ff == clk_stop_pkg::PW_RUN && fall[g])
					hold_ff[g-1] <= 1'b0;
			end
		end
	endgenerate

	// shared pin source switch
	clk_stop_pkg::share_st_e sh_st_ff, nxt_sh;
	logic [7:0] low_cnt_ff;
	logic share_sel;
	assign share_sel = src_cfg_ff[`CS_SHARE_SEL_BIT];
	always_comb begin
		nxt_sh = sh_st_ff;
		case (sh_st_ff)
			clk_stop_pkg::SH_66:
				if (share_sel && fall[1])
					nxt_sh = clk_stop_pkg::SH_LOW;
			clk_stop_pkg::SH_48:
				if (!share_sel && fall[2])
					nxt_sh = clk_stop_pkg::SH_LOW;
			clk_stop_pkg::SH_LOW:
				if (low_cnt_ff >= 8'(SHARE_LOW_CYC) && share_sel
					&& tick[2] && !phase_ff[2])
					nxt_sh = clk_stop_pkg::SH_48;
				else if (low_cnt_ff >= 8'(SHARE_LOW_CYC) && !share_sel
					&& tick[1] && !phase_ff[1])
					nxt_sh = clk_stop_pkg::SH_66;
			default: nxt_sh = clk_stop_pkg::SH_66;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_st_ff <= clk_stop_pkg::SH_66;
			low_cnt_ff <= 8'h0;
		end else begin
			sh_st_ff <= nxt_sh;
			if (sh_st_ff != clk_stop_pkg::SH_LOW)
				low_cnt_ff <= 8'h0;
			else if (low_cnt_ff != 8'hFF)
				low_cnt_ff <= low_cnt_ff + 8'h1;
		end
	end

	// differential pairs: index NCPU is the serial reference pair
	logic [NPAIR-1:0] p_oe, p_stoppable, p_stri, p_ptri;
	logic [NPAIR-1:0] p_true, p_comp, p_toe_n, p_coe_n, p_x6, p_x2;
	logic cpu_stop_req, serial_ref_halt_drive_bit_req;
	assign p_oe = {src_cfg_ff[`CS_SRC_OE_BIT],
		cpu_cfg_ff[`CS_CPU_OE_LSB +: NCPU]};
	assign p_stoppable = {src_cfg_ff[`CS_SRC_STOPPABLE_BIT],
		cpu_cfg_ff[`CS_CPU_STOPPABLE_LSB +: NCPU]};
	assign p_stri = {src_cfg_ff[`CS_SRC_STRI_BIT],
		cpu_cfg_ff[`CS_CPU_STRI_LSB +: NCPU]};
	assign p_ptri = {src_cfg_ff[`CS_SRC_PTRI_BIT],
		cpu_cfg_ff[`CS_CPU_PTRI_LSB +: NCPU]};
	assign cpu_stop_req = !pin_s2_ff[0];
	assign serial_ref_halt_drive_bit_req = !pin_s2_ff[1] || !src_cfg_ff[`CS_SW_STOP_N_BIT];

	pair_if pif [NPAIR] ();
	generate
		for (g = 0; g < NPAIR; g++) begin : g_pair
			assign pif[g].phase = phase_ff[0];
			assign pif[g].tick = tick[0];
			assign pif[g].stop_req = (g < NCPU) ? cpu_stop_req : serial_ref_halt_drive_bit_req;
			assign pif[g].free_run = !p_stoppable[g];
			assign pif[g].oe = p_oe[g];
			assign pif[g].stop_tri = p_stri[g];
			assign pif[g].pd_tri = p_ptri[g];
			assign pif[g].pd_req = (pw_st_ff != clk_stop_pkg::PW_RUN);
			assign pif[g].resume_drive = (pw_st_ff == clk_stop_pkg::PW_RESUME);
			assign p_true[g] = pif[g].true_o;
			assign p_comp[g] = pif[g].comp_o;
			assign p_toe_n[g] = pif[g].true_oe_n;
			assign p_coe_n[g] = pif[g].comp_oe_n;
			assign p_x6[g] = pif[g].drive_x6;
			assign p_x2[g] = pif[g].drive_x2;
			assign parked[g] = pif[g].parked;
			diff_pair_ctl u_pair (
				.aclk(aclk),
				.aresetn(aresetn),
				.p(pif[g])
			);
		end
	endgenerate

	assign cpu_true = p_true[NCPU-1:0];
	assign cpu_comp = p_comp[NCPU-1:0];
	assign cpu_true_oe_n = p_toe_n[NCPU-1:0];
	assign cpu_comp_oe_n = p_coe_n[NCPU-1:0];
	assign cpu_drive_x6 = p_x6[NCPU-1:0];
	assign cpu_drive_x2 = p_x2[NCPU-1:0];
	assign serial_ref_pair_true = p_true[NCPU];
	assign serial_ref_pair_comp = p_comp[NCPU];
	assign serial_ref_pair_true_oe_n = p_toe_n[NCPU];
	assign serial_ref_pair_comp_oe_n = p_coe_n[NCPU];
	assign serial_ref_pair_drive_x6 = p_x6[NCPU];
	assign serial_ref_pair_drive_x2 = p_x2[NCPU];

	// single-ended pins are registered so a hold never leaves a runt
	logic c66_ff, d48_ff, pci_ff, share_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c66_ff <= 1'b0;
			d48_ff <= 1'b0;
			pci_ff <= 1'b0;
			share_ff <= 1'b0;
		end else begin
			c66_ff <= phase_ff[1] && !hold_ff[0];
			d48_ff <= phase_ff[2] && !hold_ff[1];
			pci_ff <= phase_ff[3] && !hold_ff[2];
			case (sh_st_ff)
				clk_stop_pkg::SH_66: share_ff <= phase_ff[1] && !hold_ff[0];
				clk_stop_pkg::SH_48: share_ff <= phase_ff[2] && !hold_ff[1];
				default: share_ff <= 1'b0;
			endcase
		end
	end
	assign clk66_output = {4{c66_ff}};
	assign free_periph_clock = {3{pci_ff}};
	assign dot_clock_48 = d48_ff;
	assign shared_66_48_pin = share_ff;
	assign osc_run = osc_run_ff;

	assign status = {17'h0, osc_run_ff, sh_st_ff, parked, pw_st_ff, pin_s2_ff};

	// checking helpers
	logic [DW-1:0] drv_wait_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || pw_st_ff != clk_stop_pkg::PW_RESUME)
			drv_wait_ff <= '0;
		else if (|(parked & p_ptri & p_oe & p_toe_n) && drv_wait_ff != '1)
			drv_wait_ff <= drv_wait_ff + DW'(1);
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence pd_confirmed;
		pw_st_ff == clk_stop_pkg::PW_RUN ##1 pw_st_ff == clk_stop_pkg::PW_ENTER;
	endsequence
	pd_two_samples_a: assert property (pd_confirmed |-> $past(pd_cnt_ff) == 2'h2)
		else $error("power-down entered without two samples");
	osc_after_park_a: assert property (!osc_run_ff |-> all_parked)
		else $error("oscillator off before clocks parked");
	resume_length_a: assert property (pw_st_ff == clk_stop_pkg::PW_RESUME
		|-> res_cnt_ff < RW'(RESUME_CYC))
		else $error("resume window overran");
	resume_drive_a: assert property (drv_wait_ff < DW'(PD_DRIVE_CYC))
		else $error("tristated pair not driven high during resume");
	hold_on_fall_a: assert property ($rose(hold_ff[0]) |-> $past(fall[1]))
		else $error("66 clock held away from a falling edge");
	share_low_a: assert property (sh_st_ff == clk_stop_pkg::SH_LOW
		##1 sh_st_ff != clk_stop_pkg::SH_LOW |-> $past(low_cnt_ff)
		>= 8'(SHARE_LOW_CYC) && !$past(shared_66_48_pin))
		else $error("shared pin low gap too short");
	// cpu pair 1 stands in for all cpu pairs; they share one stop path
	stop_release_a: assert property ($fell(cpu_stop_req) && p_oe[1] &&
		!parked[1] && p_toe_n[1] && p_x6[1]
		|-> ##[1:STOP_DRIVE_CYC] !p_toe_n[1])
		else $error("released stopped pair left floating");
	share_48_a: assert property ($past(sh_st_ff) == clk_stop_pkg::SH_48
		|-> shared_66_48_pin == dot_clock_48)
		else $error("shared pin not carrying the 48 clock");
endmodule : clk_stop_ctl
`default_nettype wire

//--- hdl/diff_pair_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module diff_pair_ctl (
	input wire logic aclk,
	input wire logic aresetn,
	pair_if.pair p
);
	clk_stop_pkg::pair_st_e state_ff, nxt_state;
	logic true_ff, comp_ff, toe_n_ff, coe_n_ff, x6_ff, x2_ff;
	logic rise, fall, stop_ok, nxt_phase;

	assign rise = p.tick && !p.phase;
	assign fall = p.tick && p.phase;
	assign stop_ok = p.stop_req && !p.free_run;
	assign nxt_phase = p.phase ^ p.tick;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			clk_stop_pkg::PS_RUN: begin
				// parking on the true rising edge keeps the high phase whole
				if (p.pd_req && rise)
					nxt_state = clk_stop_pkg::PS_PD;
				else if (stop_ok && rise)
					nxt_state = clk_stop_pkg::PS_STOP;
			end
			clk_stop_pkg::PS_STOP: begin
				if (p.pd_req)
					nxt_state = clk_stop_pkg::PS_PD;
				else if (!stop_ok && fall)
					nxt_state = clk_stop_pkg::PS_RUN;
			end
			clk_stop_pkg::PS_PD: begin
				// stop level is re-read only once the resume window ends
				if (!p.pd_req && stop_ok)
					nxt_state = clk_stop_pkg::PS_STOP;
				else if (!p.pd_req && fall)
					nxt_state = clk_stop_pkg::PS_RUN;
			end
			default: nxt_state = clk_stop_pkg::PS_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_ff <= clk_stop_pkg::PS_RUN;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			true_ff <= 1'b0;
			comp_ff <= 1'b1;
			toe_n_ff <= 1'b1;
			coe_n_ff <= 1'b1;
			x6_ff <= 1'b0;
			x2_ff <= 1'b0;
		end else begin
			true_ff <= (nxt_state == clk_stop_pkg::PS_RUN) ? nxt_phase : 1'b1;
			comp_ff <= (nxt_state == clk_stop_pkg::PS_RUN) ? !nxt_phase : 1'b0;
			x6_ff <= (nxt_state == clk_stop_pkg::PS_STOP);
			x2_ff <= (nxt_state == clk_stop_pkg::PS_PD);
			if (!p.oe) begin
				toe_n_ff <= 1'b1;
				coe_n_ff <= 1'b1;
			end else if (nxt_state == clk_stop_pkg::PS_STOP) begin
				// released pair is driven high again one cycle later
				toe_n_ff <= p.stop_tri && p.stop_req;
				coe_n_ff <= p.stop_tri && p.stop_req;
			end else if (nxt_state == clk_stop_pkg::PS_PD) begin
				toe_n_ff <= p.pd_tri && !p.resume_drive;
				coe_n_ff <= !(p.pd_tri && p.resume_drive);
			end else begin
				toe_n_ff <= 1'b0;
				coe_n_ff <= 1'b0;
			end
		end
	end

	assign p.true_o = true_ff;
	assign p.comp_o = comp_ff;
	assign p.true_oe_n = toe_n_ff;
	assign p.comp_oe_n = coe_n_ff;
	assign p.drive_x6 = x6_ff;
	assign p.drive_x2 = x2_ff;
	assign p.parked = (state_ff == clk_stop_pkg::PS_PD);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	disabled_tristate_a: assert property (!p.oe |=> p.true_oe_n && p.comp_oe_n)
		else $error("disabled pair is driven");
	driven_never_tri_a: assert property (
		p.oe && !p.stop_tri && !p.pd_tri |=> !p.true_oe_n)
		else $error("pair tristated with both drive bits clear");
	stop_park_a: assert property (state_ff == clk_stop_pkg::PS_STOP |->
		true_ff && !comp_ff && x6_ff)
		else $error("stopped pair not parked high at x6");
	free_run_a: assert property (state_ff == clk_stop_pkg::PS_RUN &&
		p.free_run && !p.pd_req |=> state_ff == clk_stop_pkg::PS_RUN)
		else $error("free running pair stopped");
	pd_drive_a: assert property (state_ff == clk_stop_pkg::PS_PD &&
		p.oe && !p.pd_tri && $stable(p.oe) |-> !p.true_oe_n && p.comp_oe_n)
		else $error("driven power-down pair has wrong enables");
endmodule : diff_pair_ctl
`default_nettype wire
